//--- can_msg_buffer_assertions.sv
// assertions on the message buffer ports
`timescale 1ns/100ps
`default_nettype none
module can_msg_buffer_assertions (
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic [3:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        tx_start,
   input wire logic        tx_bit_valid,
   input wire logic        tx_done,
   input wire logic [28:0] peer_ident,
   input wire logic        arb_win
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   property p_rd_slot; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rd_slot: assert property (p_rd_slot) else $error("stray read data");
   property p_len_hi; $past(reg_rd && reg_addr == 4'hc) |-> reg_rdata[7:4] == 4'h0; endproperty
   a_len_hi: assert property (p_len_hi) else $error("length high bits set");
   property p_start; tx_start && !tx_bit_valid |=> tx_bit_valid; endproperty
   a_start: assert property (p_start) else $error("frame did not start");
   property p_min; $rose(tx_bit_valid) |-> tx_bit_valid [*8]; endproperty
   a_min: assert property (p_min) else $error("frame too short");
   // 17 bits for a bare standard frame, 99 for extended with eight bytes
   property p_max; $rose(tx_bit_valid) |-> ##[17:99] $fell(tx_bit_valid); endproperty
   a_max: assert property (p_max) else $error("frame length out of range");
   property p_done_only; tx_done |-> $fell(tx_bit_valid); endproperty
   a_done_only: assert property (p_done_only) else $error("done without frame end");
   property p_done_end; $fell(tx_bit_valid) |-> tx_done; endproperty
   a_done_end: assert property (p_done_end) else $error("frame end without done");
   property p_arb_min; $past(peer_ident) == 29'h0 |-> !arb_win; endproperty
   a_arb_min: assert property (p_arb_min) else $error("won against lowest id");
endmodule // can_msg_buffer_assertions
bind can_msg_buffer_layout can_msg_buffer_assertions i_can_msg_buffer_assertions (.ref_clk, .resetn,
   .reg_addr, .reg_rd, .reg_rdata, .tx_start, .tx_bit_valid, .tx_done, .peer_ident, .arb_win);
`default_nettype wire

//--- can_msg_buffer_layout.sv
// message buffer: register image, frame serializer and receive loader
`timescale 1ns/100ps
`default_nettype none

module can_msg_buffer_layout (
   input  wire logic                         ref_clk,
   input  wire logic                         resetn,
   input  wire logic [3:0]                   reg_addr,
   input  wire logic [7:0]                   reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic [7:0]                        reg_rdata,
   input  wire logic                         tx_start,
   output logic                              tx_bit,
   output logic                              tx_bit_valid,
   output logic                              tx_done,
   input  wire logic                         rx_load,
   input  wire can_msg_buffer_pkg::rx_frame_s rx_frame,
   input  wire logic [28:0]                  peer_ident,
   input  wire logic                         peer_ide,
   output logic                              arb_win
);
   import can_msg_buffer_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // field decoders

   function automatic logic [28:0] buf_ident(input logic [12:0][7:0] m);
      if (m[ADDR_IDENT_LOW_STD][IDE_BIT]) begin
         buf_ident = {m[ADDR_IDENT_HIGH_STD], m[ADDR_IDENT_LOW_STD][7:5], m[ADDR_IDENT_LOW_STD][2:0],
                      m[ADDR_IDENT_MID_EXT], m[ADDR_IDENT_LOW_EXT][7:1]};
      end else begin
         buf_ident = {18'h00000, m[ADDR_IDENT_HIGH_STD], m[ADDR_IDENT_LOW_STD][7:5]};
      end
   endfunction

   function automatic logic buf_rtr(input logic [12:0][7:0] m);
      if (m[ADDR_IDENT_LOW_STD][IDE_BIT]) begin
         buf_rtr = m[ADDR_IDENT_LOW_EXT][EXT_RTR_BIT];
      end else begin
         buf_rtr = m[ADDR_IDENT_LOW_STD][STD_RTR_BIT];
      end
   endfunction

   // remote frames carry no payload; oversize codes clamp to eight
   function automatic logic [3:0] byte_count(input logic rtr, input logic [3:0] dlc);
      if (rtr) begin
         byte_count = 4'h0;
      end else if (dlc > MAX_DATA_COUNT) begin
         byte_count = MAX_DATA_COUNT;
      end else begin
         byte_count = dlc;
      end
   endfunction

   // standard ids sit in the top of the 29-bit space so one compare serves both
   function automatic logic [28:0] arb_key(input logic [28:0] id, input logic ext);
      if (ext) begin
         arb_key = id;
      end else begin
         arb_key = {id[10:0], 18'h00000};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   state_s st_r;
   state_s st_nxt;

   logic [28:0] own_ident;
   logic        own_ext;
   logic        own_rtr;
   logic [3:0]  own_dlc;
   logic [3:0]  own_count;
   logic [5:0]  ctrl_w;
   logic [63:0] payload_w;
   logic [3:0]  rx_count;
   logic [6:0]  last_data;

   always_comb begin
      own_ident = buf_ident(st_r.mem);
      own_ext   = st_r.mem[ADDR_IDENT_LOW_STD][IDE_BIT];
      own_rtr   = buf_rtr(st_r.mem);
      own_dlc   = st_r.mem[ADDR_FRAME_LENGTH][3:0];
      own_count = byte_count(own_rtr, own_dlc);
      ctrl_w    = {own_rtr, own_ext, own_dlc};
      for (int i = 0; i < PAYLOAD_BYTES; i++) begin
         payload_w[63 - 8*i -: 8] = st_r.mem[ADDR_PAYLOAD0 + i];
      end
      rx_count  = byte_count(rx_frame.rtr, rx_frame.dlc);
      last_data = 7'({own_count, 3'b000} - 7'h01);
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_nxt         = st_r;
      st_nxt.tx_done = 1'b0;
      st_nxt.rd_data = 8'h00;

      // buffer is frozen while a frame goes out, so the serializer sees stable fields
      if (st_r.phase == TX_IDLE) begin
         if (reg_wr) begin
            if (reg_addr == ADDR_FRAME_LENGTH) begin
               st_nxt.mem[ADDR_FRAME_LENGTH] = {4'h0, reg_wdata[3:0]};
            end else if (reg_addr < ADDR_FRAME_LENGTH) begin
               st_nxt.mem[reg_addr] = reg_wdata;
            end
         end
         // a received frame wins over a write in the same cycle on the bytes it loads
         if (rx_load) begin
            if (rx_frame.ide) begin
               st_nxt.mem[ADDR_IDENT_HIGH_STD] = rx_frame.ident[28:21];
               st_nxt.mem[ADDR_IDENT_LOW_STD]  = {rx_frame.ident[20:18], rx_frame.srr, 1'b1,
                                                  rx_frame.ident[17:15]};
               st_nxt.mem[ADDR_IDENT_MID_EXT]  = rx_frame.ident[14:7];
               st_nxt.mem[ADDR_IDENT_LOW_EXT]  = {rx_frame.ident[6:0], rx_frame.rtr};
            end else begin
               st_nxt.mem[ADDR_IDENT_HIGH_STD] = rx_frame.ident[10:3];
               st_nxt.mem[ADDR_IDENT_LOW_STD]  = {rx_frame.ident[2:0], rx_frame.rtr, 1'b0, 3'b000};
            end
            st_nxt.mem[ADDR_FRAME_LENGTH] = {4'h0, rx_frame.dlc};
            for (int i = 0; i < PAYLOAD_BYTES; i++) begin
               if (4'(i) < rx_count) begin
                  st_nxt.mem[ADDR_PAYLOAD0 + i] = rx_frame.payload_bytes[i];
               end
            end
         end
      end

      if (reg_rd) begin
         if (reg_addr <= ADDR_FRAME_LENGTH) begin
            st_nxt.rd_data = st_r.mem[reg_addr];
         end
      end

      // serializer: identifier msb first, then rtr, ide, length code, payload
      case (st_r.phase)
         TX_IDLE: begin
            st_nxt.tx_valid = 1'b0;
            if (tx_start) begin
               st_nxt.phase    = TX_IDENT;
               st_nxt.cnt      = own_ext ? EXT_ID_TOP : STD_ID_TOP;
               st_nxt.tx_bit   = own_ident[st_nxt.cnt[4:0]];
               st_nxt.tx_valid = 1'b1;
            end
         end
         TX_IDENT: begin
            if (st_r.cnt == 7'h00) begin
               st_nxt.phase  = TX_CTRL;
               st_nxt.cnt    = CTRL_TOP;
               st_nxt.tx_bit = ctrl_w[5];
            end else begin
               st_nxt.cnt    = st_r.cnt - 7'h01;
               st_nxt.tx_bit = own_ident[st_nxt.cnt[4:0]];
            end
         end
         TX_CTRL: begin
            if (st_r.cnt == 7'h00) begin
               if (own_count == 4'h0) begin
                  st_nxt.phase    = TX_IDLE;
                  st_nxt.tx_valid = 1'b0;
                  st_nxt.tx_done  = 1'b1;
               end else begin
                  st_nxt.phase  = TX_DATA;
                  st_nxt.cnt    = 7'h00;
                  st_nxt.tx_bit = payload_w[63];
               end
            end else begin
               st_nxt.cnt    = st_r.cnt - 7'h01;
               st_nxt.tx_bit = ctrl_w[st_nxt.cnt[2:0]];
            end
         end
         TX_DATA: begin
            if (st_r.cnt == last_data) begin
               st_nxt.phase    = TX_IDLE;
               st_nxt.tx_valid = 1'b0;
               st_nxt.tx_done  = 1'b1;
            end else begin
               st_nxt.cnt    = st_r.cnt + 7'h01;
               st_nxt.tx_bit = payload_w[6'(7'h3f - st_nxt.cnt)];
            end
         end
         default: begin
            st_nxt.phase = TX_IDLE;
         end
      endcase

      // ties do not count as a win
      st_nxt.arb_win = arb_key(own_ident, own_ext) < arb_key(peer_ident, peer_ide);
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '{mem: {BUF_BYTES{BYTE_RESET}}, rd_data: 8'h00, phase: TX_IDLE, cnt: 7'h00,
                   tx_bit: 1'b0, tx_valid: 1'b0, tx_done: 1'b0, arb_win: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata    = st_r.rd_data;
   assign tx_bit       = st_r.tx_bit;
   assign tx_bit_valid = st_r.tx_valid;
   assign tx_done      = st_r.tx_done;
   assign arb_win      = st_r.arb_win;

endmodule // can_msg_buffer_layout

`default_nettype wire

//--- can_msg_buffer_pkg.sv
// constants, field layouts and carrier types for the message buffer
package can_msg_buffer_pkg;

   // byte offsets on the register port
   localparam logic [3:0] ADDR_IDENT_HIGH_STD = 4'h0;
   localparam logic [3:0] ADDR_IDENT_LOW_STD  = 4'h1;
   localparam logic [3:0] ADDR_IDENT_MID_EXT  = 4'h2;
   localparam logic [3:0] ADDR_IDENT_LOW_EXT  = 4'h3;
   localparam logic [3:0] ADDR_PAYLOAD0       = 4'h4;
   localparam logic [3:0] ADDR_FRAME_LENGTH   = 4'hc;

   localparam int unsigned BUF_BYTES      = 13;
   localparam int unsigned PAYLOAD_BYTES  = 8;

   // field positions
   localparam int unsigned IDE_BIT        = 3;
   localparam int unsigned STD_RTR_BIT    = 4;
   localparam int unsigned SRR_BIT        = 4;
   localparam int unsigned EXT_RTR_BIT    = 0;

   // identifier widths and serial counts
   localparam int unsigned EXT_ID_BITS    = 29;
   localparam int unsigned STD_ID_BITS    = 11;
   localparam logic [6:0]  EXT_ID_TOP     = 7'h1c;
   localparam logic [6:0]  STD_ID_TOP     = 7'h0a;
   localparam logic [6:0]  CTRL_TOP       = 7'h05;
   localparam logic [3:0]  MAX_DATA_COUNT = 4'h8;

   // reset values
   localparam logic [7:0]  BYTE_RESET     = 8'h00;

   typedef enum logic [1:0] {
      TX_IDLE,
      TX_IDENT,
      TX_CTRL,
      TX_DATA
   } tx_phase_e;

   typedef struct packed {
      logic [28:0]     ident;
      logic            ide;
      logic            rtr;
      logic            srr;
      logic [3:0]      dlc;
      logic [7:0][7:0] payload_bytes;
   } rx_frame_s;

   typedef struct packed {
      logic [12:0][7:0] mem;
      logic [7:0]       rd_data;
      tx_phase_e        phase;
      logic [6:0]       cnt;
      logic             tx_bit;
      logic             tx_valid;
      logic             tx_done;
      logic             arb_win;
   } state_s;

endpackage

//--- can_peer_node.sv
// peer node: offers received frames and a competing identifier
`timescale 1ns/100ps
`default_nettype none
module can_peer_node (
   input  wire logic                          ref_clk,
   input  wire logic                          resetn,
   input  wire logic                          offer,
   input  wire can_msg_buffer_pkg::rx_frame_s offer_frame,
   input  wire logic [28:0]                   cmp_id,
   input  wire logic                          cmp_ide,
   output logic                               rx_load,
   output can_msg_buffer_pkg::rx_frame_s      rx_frame,
   output logic [28:0]                        peer_ident,
   output logic                               peer_ide
);
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rx_load    <= 1'b0;
         rx_frame   <= '0;
         peer_ident <= 29'h0;
         peer_ide   <= 1'b0;
      end else begin
         rx_load    <= offer;
         // idle frame bus toggles so a stale frame never looks live
         rx_frame   <= offer ? offer_frame : ~rx_frame;
         peer_ident <= cmp_id;
         peer_ide   <= cmp_ide;
      end
   end
endmodule // can_peer_node
`default_nettype wire

//--- tb.sv
// self-checking bench for the message buffer
`timescale 1ns/100ps
`default_nettype none
module tb;
   import can_msg_buffer_pkg::*;
   logic        ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, tx_start = 0, offer = 0, cmp_ide = 0;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata;
   logic        tx_bit, tx_bit_valid, tx_done, rx_load, peer_ide, arb_win;
   logic [28:0] peer_ident, cmp_id = 29'h0;
   rx_frame_s   rx_frame, offer_frame = '0;
   int          n_fail = 0, tests_run = 0, cyc = 0;
   initial forever #12.5 ref_clk = ~ref_clk;
   can_msg_buffer_layout i_can_msg_buffer_layout (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .tx_start, .tx_bit, .tx_bit_valid, .tx_done, .rx_load, .rx_frame, .peer_ident, .peer_ide, .arb_win);
   can_peer_node i_can_peer_node (.ref_clk, .resetn, .offer, .offer_frame, .cmp_id, .cmp_ide, .rx_load, .rx_frame,
      .peer_ident, .peer_ide);
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp, "read");
   endtask
   task automatic t_regs;
      for (int a = 0; a < 16; a++) begin
         rd(a[3:0], 8'h00);
         wr(a[3:0], 8'ha0 + a[7:0]);
         rd(a[3:0], a > 12 ? 8'h00 : (a == 12 ? 8'h0c : 8'ha0 + a[7:0]));
      end
      $display("t_regs done");
   endtask
   task automatic send(input logic ide, input logic [28:0] id, input logic rtr, input logic [3:0] dlc);
      logic q[$];
      logic e[$];
      int   n;
      wr(4'h0, ide ? id[28:21] : id[10:3]);
      wr(4'h1, ide ? {id[20:18], 2'b11, id[17:15]} : {id[2:0], rtr, 4'h0});
      wr(4'h2, id[14:7]);
      wr(4'h3, {id[6:0], rtr});
      wr(4'hc, {4'h0, dlc});
      for (int b = 0; b < 8; b++) wr(4'h4 + b[3:0], 8'h10 + b[7:0]);
      for (int i = ide ? 28 : 10; i >= 0; i--) e.push_back(id[i]);
      e.push_back(rtr);
      e.push_back(ide);
      for (int i = 3; i >= 0; i--) e.push_back(dlc[i]);
      n = rtr ? 0 : (dlc > 8 ? 8 : int'(dlc));
      for (int j = 0; j < n * 8; j++) e.push_back(1'((16 + j / 8) >> (7 - j % 8)));
      @(posedge ref_clk);
      tx_start <= 1'b1;
      @(posedge ref_clk);
      tx_start <= 1'b0;
      for (int k = 0; k < 120; k++) begin
         #1;
         if (tx_bit_valid === 1'b1) q.push_back(tx_bit);
         if (tx_done === 1'b1) break;
         @(posedge ref_clk);
      end
      chk(tx_done, 1'b1, "frame done");
      chk(q.size(), e.size(), "frame length");
      foreach (e[i]) chk(i < q.size() ? q[i] : 1'bx, e[i], "frame bit");
      $display("frame %h done", id);
   endtask
   task automatic t_rx;
      logic [28:0] id = 29'h15a5a5a5;
      logic [7:0]  ex [13];
      ex = '{id[28:21], {id[20:18], 2'b01, id[17:15]}, id[14:7], {id[6:0], 1'b0}, 8'ha5, 8'h11, 8'h22,
             8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h03};
      @(posedge ref_clk);
      offer <= 1'b1;
      offer_frame <= '{ident: id, ide: 1'b1, rtr: 1'b0, srr: 1'b0, dlc: 4'h3, payload_bytes: 64'h77665544332211a5};
      @(posedge ref_clk);
      offer <= 1'b0;
      repeat (2) @(posedge ref_clk);
      for (int a = 0; a < 13; a++) rd(a[3:0], ex[a]);
      $display("t_rx done");
   endtask
   task automatic t_arb;
      logic [28:0] pid [4] = '{29'h0, 29'h15a5a5a4, 29'h15a5a5a5, 29'h15a5a5a6};
      for (int k = 0; k < 4; k++) begin
         @(posedge ref_clk);
         cmp_id <= pid[k];
         cmp_ide <= 1'b1;
         repeat (3) @(posedge ref_clk);
         #1 chk(arb_win, k == 3, "arbitration");
      end
      $display("t_arb done");
   endtask
   task automatic results;
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      t_regs();
      send(1'b0, 29'h5a3, 1'b0, 4'h2);
      send(1'b0, 29'h7ff, 1'b1, 4'h5);
      send(1'b0, 29'h001, 1'b0, 4'h9);
      send(1'b1, 29'h0aaaa555, 1'b1, 4'h3);
      send(1'b1, 29'h1234abcd, 1'b0, 4'h8);
      t_rx();
      t_arb();
      results();
   end
endmodule // tb
`default_nettype wire
